// ===== clock_reset_control_consts.svh
// Contract
// [RULE1] reset halts cpu, loads registers, stops interrupts
// [RULE2] reset keeps data memory, reinitialises stack pointer
// [RULE3] ports load all ones, open drain, pullups
// [RULE4] power resets drive reset pin low
// [RULE5] exit clears counter, fetch zero, oscillator clock
// [RULE6] watchdog enabled on exit, clock divided twelve
// [RULE7] read timing reset value suits 25 MHz
// [RULE8] flash strobe lasts one or two clocks
// [RULE9] flash active only while strobe asserted
// [RULE10] software sets long timing above 25 MHz
// [RULE11] timing change: slow clock, prefetch off, write
// [RULE12] writing suspend bit stops internal oscillator
// [RULE13] suspended oscillator clock stops cpu and peripherals
// [RULE14] wake: port match or comparator low
// [RULE15] wake restarts oscillator, cpu and peripherals
// [RULE16] cpu continues after the suspending write
// [RULE17] software suspends off oscillator, reinitialises pll
// [RULE18] software selects reference, timing, then pll power
// [RULE19] software programs divider, filter ranges, multiplier
// [RULE20] software waits 5 us before pll enable
// [RULE21] software waits for lock before selecting pll
// [RULE22] software leaves and disables pll before reprogramming
// [RULE23] software disables cache while lowering timing
// [RULE24] lock set when stable, cleared when disabled
// [RULE25] clock source switch is glitch free
// [RULE26] strobe length changes only between accesses
`ifndef CLOCK_RESET_CONTROL_CONSTS_SVH
`define CLOCK_RESET_CONTROL_CONSTS_SVH
`define REG_OSC 4'h0
`define REG_FLASH 4'h1
`define REG_CACHE 4'h2
`define REG_PLL 4'h3
`define REG_PDIV 4'h4
`define REG_PFLT 4'h5
`define REG_PMUL 4'h6
`define REG_SYSTEM_CLOCK_SOURCE_SELECT 4'h7
`define SUSPEND_BIT 5
`define FRT_LO 4
`define FRT_HI 5
`define FRT_RST 2'h0
`define PREF_BIT 0
`define PREF_RST 1'h1
`define PLL_PWR_BIT 0
`define PLL_EN_BIT 1
`define PLL_SRC_BIT 2
`define PLL_LCK_BIT 4
`define LP_HI 3
`define ICO_LO 4
`define ICO_HI 5
`define SYSTEM_CLOCK_SOURCE_SELECT_BIT 0
`define CLKACT_BIT 4
`define SRC_OSC 1'h0
`define SRC_PLL 1'h1
`define WDT_DIV 4'hc
`define PORT_RST 8'hff
`define PC_RST 16'h0000
`define CLK_PERIOD_PS 8000
`define PLL_SETTLE_NS 5000
`define PLL_SETTLE_CYC \
   ((`PLL_SETTLE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// ===== clock_reset_pkg.sv
package clock_reset_pkg;
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_RUN = 2'b01,
      ST_SUSPEND = 2'b10
   } mode_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } reg_req_t;
   typedef struct packed {
      logic power;
      logic run;
      logic ref_sel;
      logic [7:0] div;
      logic [3:0] loop_range;
      logic [1:0] osc_range;
      logic [7:0] mult;
   } pll_cfg_t;
   typedef struct packed {
      logic load;
      logic [7:0] value;
      logic open_drain;
      logic pullup_en;
   } port_init_t;
   typedef struct packed {
      mode_t mode;
      logic por_drive;
      logic pc_clear;
      logic suspend;
      logic [1:0] flash_rt;
      logic prefetch;
      pll_cfg_t pll;
      logic clk_sel;
      logic cur_src;
      logic holdoff;
      logic lock;
      logic [15:0] lock_cnt;
      logic strobe;
      logic strobe_left;
      logic [3:0] wdt_cnt;
      logic wdt_tick;
      logic system_clock_en;
      logic [7:0] rdata;
   } state_t;
endpackage

// ===== clock_reset_control.sv
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "clock_reset_control_consts.svh"
module clock_reset_control import clock_reset_pkg::*; #(
   parameter int unsigned LOCK_CYCLES = `PLL_SETTLE_CYC
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_por_reset,
   input wire reg_req_t i_reg_req,
   output logic [7:0] o_reg_rdata,
   input wire logic i_osc_tick,
   input wire logic i_pll_tick,
   input wire logic i_flash_req,
   input wire logic [2:0] i_port_match,
   input wire logic [1:0] i_cmp_en,
   input wire logic [1:0] i_cmp_out,
   output logic o_system_clock_en,
   output logic o_system_clock_src,
   output logic o_osc_run,
   output logic o_cpu_halt,
   output logic o_sfr_reset,
   output logic o_intr_timer_disable,
   output logic o_sp_init,
   output logic o_ram_write_block,
   output logic o_pc_clear,
   output logic [15:0] o_pc_value,
   output port_init_t o_port_init,
   output logic o_rst_pin_out,
   output logic o_rst_pin_oe_n,
   output logic o_wdt_enable,
   output logic o_wdt_tick,
   output logic o_flash_rd_strobe,
   output logic o_flash_active,
   output logic o_flash_low_power,
   output logic o_flash_busy,
   output logic o_prefetch_enable,
   output pll_cfg_t o_pll_cfg,
   output logic o_pll_locked
);

   state_t s;
   state_t next_s;
   logic wake;
   logic sel_tick;
   logic gate;

   // ---------------------------------------------------------------
   // wake sources and clock selection
   // ---------------------------------------------------------------
   assign wake = (|i_port_match) | (|(i_cmp_en & ~i_cmp_out)); // [RULE14]
   assign sel_tick = (s.cur_src == `SRC_PLL) ? i_pll_tick : i_osc_tick;
   // only an oscillator-derived clock is stopped by suspend
   assign gate = s.suspend && (s.cur_src == `SRC_OSC); // [RULE13]

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.pc_clear = 1'b0;
      next_s.wdt_tick = 1'b0;
      next_s.system_clock_en = 1'b0;
      next_s.rdata = 8'h00;
      if (!i_resetn) begin
         next_s = '0; // [RULE1] [RULE2]
         next_s.mode = ST_RESET;
         next_s.flash_rt = `FRT_RST; // [RULE7]
         next_s.prefetch = `PREF_RST;
         next_s.clk_sel = `SRC_OSC; // [RULE5]
         next_s.cur_src = `SRC_OSC;
         // cause is remembered for the whole reset
         next_s.por_drive = s.por_drive | i_por_reset; // [RULE4]
      end else begin
         // register writes
         if (i_reg_req.we) begin
            case (i_reg_req.addr)
               `REG_OSC: begin
                  if (i_reg_req.wdata[`SUSPEND_BIT]) begin
                     next_s.suspend = 1'b1; // [RULE12]
                  end
               end
               `REG_FLASH: begin
                  next_s.flash_rt = i_reg_req.wdata[`FRT_HI:`FRT_LO];
               end
               `REG_CACHE: begin
                  next_s.prefetch = i_reg_req.wdata[`PREF_BIT];
               end
               `REG_PLL: begin
                  next_s.pll.power = i_reg_req.wdata[`PLL_PWR_BIT];
                  next_s.pll.run = i_reg_req.wdata[`PLL_EN_BIT];
                  next_s.pll.ref_sel = i_reg_req.wdata[`PLL_SRC_BIT];
               end
               `REG_PDIV: begin
                  next_s.pll.div = i_reg_req.wdata;
               end
               `REG_PFLT: begin
                  next_s.pll.loop_range = i_reg_req.wdata[`LP_HI:0];
                  next_s.pll.osc_range =
                     i_reg_req.wdata[`ICO_HI:`ICO_LO];
               end
               `REG_PMUL: begin
                  next_s.pll.mult = i_reg_req.wdata;
               end
               `REG_SYSTEM_CLOCK_SOURCE_SELECT: begin
                  next_s.clk_sel = i_reg_req.wdata[`SYSTEM_CLOCK_SOURCE_SELECT_BIT];
               end
               default: begin
               end
            endcase
         end
         // a wake in the writing cycle wins, so no event is lost
         if (wake) begin
            next_s.suspend = 1'b0; // [RULE15]
         end

         // register reads, data in the following cycle
         if (i_reg_req.re) begin
            case (i_reg_req.addr)
               `REG_OSC: next_s.rdata[`SUSPEND_BIT] = s.suspend;
               `REG_FLASH: next_s.rdata[`FRT_HI:`FRT_LO] = s.flash_rt;
               `REG_CACHE: next_s.rdata[`PREF_BIT] = s.prefetch;
               `REG_PLL: begin
                  next_s.rdata[`PLL_PWR_BIT] = s.pll.power;
                  next_s.rdata[`PLL_EN_BIT] = s.pll.run;
                  next_s.rdata[`PLL_SRC_BIT] = s.pll.ref_sel;
                  next_s.rdata[`PLL_LCK_BIT] = s.lock;
               end
               `REG_PDIV: next_s.rdata = s.pll.div;
               `REG_PFLT: begin
                  next_s.rdata[`LP_HI:0] = s.pll.loop_range;
                  next_s.rdata[`ICO_HI:`ICO_LO] = s.pll.osc_range;
               end
               `REG_PMUL: next_s.rdata = s.pll.mult;
               `REG_SYSTEM_CLOCK_SOURCE_SELECT: begin
                  next_s.rdata[`SYSTEM_CLOCK_SOURCE_SELECT_BIT] = s.clk_sel;
                  next_s.rdata[`CLKACT_BIT] = s.cur_src;
               end
               default: next_s.rdata = 8'h00;
            endcase
         end

         // operating mode
         unique case (s.mode)
            ST_RESET: begin
               next_s.mode = ST_RUN;
               next_s.pc_clear = 1'b1; // [RULE5]
               next_s.por_drive = 1'b0; // [RULE4]
            end
            ST_RUN, ST_SUSPEND: begin
               next_s.mode = next_s.suspend ? ST_SUSPEND : ST_RUN;
            end
            default: next_s.mode = ST_RESET;
         endcase

         // lock flag: hardware only, lost as soon as pll stops
         if (s.pll.power && s.pll.run) begin
            if (s.lock_cnt >= 16'(LOCK_CYCLES)) begin
               next_s.lock = 1'b1; // [RULE24]
            end else begin
               next_s.lock_cnt = s.lock_cnt + 16'h0001;
            end
         end else begin
            next_s.lock = 1'b0; // [RULE24]
            next_s.lock_cnt = 16'h0000;
         end

         // source switch happens on an edge of the old source and
         // the first edge of the new one is swallowed, so no
         // shortened period reaches the core; an unlocked pll falls
         // back to the oscillator at once since its edges are gone
         if (s.cur_src == `SRC_PLL && !s.lock) begin
            next_s.cur_src = `SRC_OSC; // [RULE25]
            next_s.holdoff = 1'b1;
         end else if (s.clk_sel != s.cur_src && sel_tick &&
                      (s.clk_sel == `SRC_OSC || s.lock)) begin
            next_s.cur_src = s.clk_sel; // [RULE25]
            next_s.holdoff = 1'b1;
         end else if (s.holdoff && sel_tick) begin
            next_s.holdoff = 1'b0;
         end
         // gating holds the core mid-program, so it simply
         // continues after the suspending write on wake
         next_s.system_clock_en = sel_tick & ~s.holdoff & ~gate; // [RULE16]

         // flash strobe, length frozen when the access starts
         if (s.system_clock_en) begin
            if (s.strobe && s.strobe_left) begin
               next_s.strobe_left = 1'b0; // [RULE8]
            end else begin
               next_s.strobe = i_flash_req; // [RULE8]
               next_s.strobe_left = i_flash_req &&
                  (s.flash_rt != `FRT_RST); // [RULE26]
            end
         end

         // watchdog time base
         if (s.system_clock_en) begin
            if (s.wdt_cnt == `WDT_DIV - 4'h1) begin
               next_s.wdt_cnt = 4'h0;
               next_s.wdt_tick = 1'b1; // [RULE6]
            end else begin
               next_s.wdt_cnt = s.wdt_cnt + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      s <= next_s;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign o_reg_rdata = s.rdata;
   assign o_system_clock_en = s.system_clock_en;
   assign o_system_clock_src = s.cur_src;
   assign o_osc_run = ~s.suspend; // [RULE12] [RULE15]
   assign o_cpu_halt = (s.mode == ST_RESET); // [RULE1]
   assign o_sfr_reset = (s.mode == ST_RESET); // [RULE1]
   assign o_intr_timer_disable = (s.mode == ST_RESET); // [RULE1]
   // data memory is never cleared, only shielded from stray writes
   assign o_sp_init = (s.mode == ST_RESET); // [RULE2]
   assign o_ram_write_block = (s.mode == ST_RESET); // [RULE2]
   assign o_pc_clear = s.pc_clear; // [RULE5]
   assign o_pc_value = `PC_RST;
   assign o_port_init.load = (s.mode == ST_RESET); // [RULE3]
   assign o_port_init.value = `PORT_RST;
   assign o_port_init.open_drain = (s.mode == ST_RESET);
   assign o_port_init.pullup_en = 1'b1; // [RULE3]
   assign o_rst_pin_out = 1'b0;
   assign o_rst_pin_oe_n = ~s.por_drive; // [RULE4]
   assign o_wdt_enable = (s.mode != ST_RESET); // [RULE6]
   assign o_wdt_tick = s.wdt_tick;
   assign o_flash_rd_strobe = s.strobe;
   assign o_flash_active = s.strobe; // [RULE9]
   assign o_flash_low_power = ~s.strobe; // [RULE9]
   assign o_flash_busy = s.strobe & s.strobe_left;
   assign o_prefetch_enable = s.prefetch;
   assign o_pll_cfg = s.pll;
   assign o_pll_locked = s.lock;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_short_start;
      s.system_clock_en && i_flash_req && !o_flash_busy &&
         s.flash_rt == `FRT_RST;
   endsequence
   sequence s_long_start;
      s.system_clock_en && i_flash_req && !o_flash_busy &&
         s.flash_rt != `FRT_RST;
   endsequence
   sequence s_suspend_write;
      i_reg_req.we && i_reg_req.addr == `REG_OSC &&
         i_reg_req.wdata[`SUSPEND_BIT] && !wake;
   endsequence

   a_reset_exit: assert property ( // [RULE1] [RULE5] [RULE6]
      $rose(i_resetn) |-> o_cpu_halt && o_intr_timer_disable ##1
         !o_cpu_halt && o_pc_clear && o_wdt_enable &&
         o_system_clock_src == `SRC_OSC)
      else $error("reset exit sequence wrong");
   a_ram_stack: assert property ( // [RULE2]
      $rose(i_resetn) |-> o_sp_init && o_ram_write_block ##1
         !o_ram_write_block)
      else $error("memory guard wrong at reset exit");
   a_port_init: assert property ( // [RULE3]
      $rose(i_resetn) |-> o_port_init.load && o_port_init.open_drain &&
         o_port_init.value == `PORT_RST ##1 o_port_init.pullup_en)
      else $error("port reset state wrong");
   a_pin_release: assert property ( // [RULE4]
      !o_cpu_halt |-> o_rst_pin_oe_n)
      else $error("reset pin driven outside reset");
   a_timing_reset: assert property ( // [RULE7]
      $rose(i_resetn) |-> s.flash_rt == `FRT_RST)
      else $error("read timing reset value wrong");
   a_strobe_short: assert property ( // [RULE8]
      s_short_start |=> o_flash_rd_strobe && !o_flash_busy)
      else $error("short strobe wrong");
   a_strobe_long: assert property ( // [RULE8] [RULE26]
      s_long_start |=> o_flash_rd_strobe && o_flash_busy)
      else $error("long strobe wrong");
   a_strobe_hold: assert property ( // [RULE26]
      o_flash_busy && !s.system_clock_en |=> o_flash_busy && o_flash_rd_strobe)
      else $error("strobe cut mid access");
   a_flash_power: assert property ( // [RULE9]
      o_flash_active == o_flash_rd_strobe &&
         o_flash_low_power != o_flash_rd_strobe)
      else $error("flash power state wrong");
   a_suspend_set: assert property ( // [RULE12]
      s_suspend_write |=> !o_osc_run)
      else $error("suspend write ignored");
   a_suspend_gate: assert property ( // [RULE13] [RULE16]
      s.suspend && s.cur_src == `SRC_OSC |=> !o_system_clock_en)
      else $error("clock ran while suspended");
   a_wake_run: assert property ( // [RULE14] [RULE15]
      s.suspend && (|i_port_match) |=> o_osc_run ##1 o_osc_run)
      else $error("wake did not restart oscillator");
   a_lock_clear: assert property ( // [RULE24]
      !(s.pll.power && s.pll.run) |=> !o_pll_locked)
      else $error("lock flag held while pll off");
   a_lock_wait: assert property ( // [RULE24]
      $rose(s.pll.power && s.pll.run) |-> !o_pll_locked [*8])
      else $error("lock flag set too early");
   a_switch_clean: assert property ( // [RULE25]
      $changed(s.cur_src) |-> s.holdoff ##1 !o_system_clock_en)
      else $error("clock switch without gap");

   // reset exit gives one clear pulse, and the watchdog only ticks
   // once it has been enabled
   a_pc_pulse: assert property ( // [RULE5]
      o_pc_clear |=> !o_pc_clear)
      else $error("program counter clear not a pulse");
   a_wdt_gate: assert property ( // [RULE6]
      o_wdt_tick |-> o_wdt_enable)
      else $error("watchdog ticked while disabled");
   // the pin must go low while reset is still held, so this check
   // cannot use the default disable
   a_por_drive: assert property ( // [RULE4]
      disable iff (1'b0)
      !i_resetn && i_por_reset |=> !o_rst_pin_oe_n)
      else $error("reset pin not driven on power reset");
   // a one tick strobe drops at the next enable unless renewed
   a_strobe_end: assert property ( // [RULE8] [RULE9]
      o_flash_rd_strobe && !o_flash_busy && s.system_clock_en && !i_flash_req
         |=> !o_flash_rd_strobe && o_flash_low_power)
      else $error("short strobe did not end");
   a_cmp_wake: assert property ( // [RULE14] [RULE15]
      s.suspend && (|(i_cmp_en & ~i_cmp_out)) |=> o_osc_run)
      else $error("comparator did not wake oscillator");
   // a switch to the pll is only legal from a locked state, and a
   // lost lock must hand the core back to the oscillator at once
   a_switch_locked: assert property ( // [RULE25]
      $rose(o_system_clock_src) |-> $past(o_pll_locked))
      else $error("pll selected before lock");
   a_fallback: assert property ( // [RULE24] [RULE25]
      o_system_clock_src == `SRC_PLL && !o_pll_locked |=>
         o_system_clock_src == `SRC_OSC)
      else $error("no fallback after lock loss");
endmodule

// ===== clock_sources_model.sv
`timescale 1ns/1ps
module clock_sources_model (
   input wire logic i_core_clk,
   input wire logic i_osc_run,
   input wire logic i_pll_power,
   output logic o_osc_tick,
   output logic o_pll_tick
);
   logic [1:0] osc_div;
   // -----------------------------
   // oscillator and pll sources
   // -----------------------------
   // osc ticks every third cycle, pll every other: the pll must look faster
   initial begin
      osc_div = 2'h0;
      o_osc_tick = 1'b0;
      o_pll_tick = 1'b0;
   end
   always @(posedge i_core_clk) begin
      osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
      // a suspended oscillator gives no ticks at all
      o_osc_tick <= i_osc_run && (osc_div == 2'h2);
      o_pll_tick <= i_pll_power && !o_pll_tick;
   end
endmodule

// ===== clock_reset_control_tb.sv
`timescale 1ns/1ps
module clock_reset_control_tb import clock_reset_pkg::*;;
   logic i_core_clk, i_resetn, i_por_reset, i_flash_req;
   reg_req_t i_reg_req;
   logic [2:0] i_port_match;
   logic [1:0] i_cmp_en, i_cmp_out;
   logic i_osc_tick, i_pll_tick, o_system_clock_en, o_system_clock_src, o_osc_run;
   logic o_cpu_halt, o_sfr_reset, o_intr_timer_disable, o_sp_init;
   logic o_ram_write_block, o_pc_clear, o_rst_pin_out, o_rst_pin_oe_n;
   logic o_wdt_enable, o_wdt_tick, o_flash_rd_strobe, o_flash_active;
   logic o_flash_low_power, o_flash_busy, o_prefetch_enable, o_pll_locked;
   logic [7:0] o_reg_rdata, got;
   logic [15:0] o_pc_value;
   port_init_t o_port_init;
   pll_cfg_t o_pll_cfg;
   int n_fail = 0, samples_checked = 0, hits, k;

   clock_reset_control #(.LOCK_CYCLES(8)) u_dut (.i_core_clk, .i_resetn,
      .i_por_reset, .i_reg_req, .o_reg_rdata, .i_osc_tick, .i_pll_tick,
      .i_flash_req, .i_port_match, .i_cmp_en, .i_cmp_out, .o_system_clock_en,
      .o_system_clock_src, .o_osc_run, .o_cpu_halt, .o_sfr_reset,
      .o_intr_timer_disable, .o_sp_init, .o_ram_write_block, .o_pc_clear,
      .o_pc_value, .o_port_init, .o_rst_pin_out, .o_rst_pin_oe_n,
      .o_wdt_enable, .o_wdt_tick, .o_flash_rd_strobe, .o_flash_active,
      .o_flash_low_power, .o_flash_busy, .o_prefetch_enable, .o_pll_cfg,
      .o_pll_locked);
   clock_sources_model u_src (.i_core_clk, .i_osc_run(o_osc_run),
      .i_pll_power(o_pll_cfg.power), .o_osc_tick(i_osc_tick),
      .o_pll_tick(i_pll_tick));

   // -----------------------------
   // access tasks
   // -----------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // the idle cycle after each strobe keeps a driver from assigning twice
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      i_reg_req.addr <= a;
      i_reg_req.wdata <= d;
      i_reg_req.we <= 1'b1;
      @(posedge i_core_clk);
      i_reg_req.we <= 1'b0;
      @(posedge i_core_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
                     input string nm);
      i_reg_req.addr <= a;
      i_reg_req.re <= 1'b1;
      @(posedge i_core_clk);
      i_reg_req.re <= 1'b0;
      #1;
      got = o_reg_rdata;
      if (nm != "") chk(nm, e, got);
      @(posedge i_core_clk);
   endtask
   task automatic count_en(input int n);
      hits = 0;
      repeat (n) begin
         @(posedge i_core_clk);
         #1;
         if (o_system_clock_en === 1'b1) hits++;
      end
      @(posedge i_core_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      i_core_clk = 1'b0;
      forever #4 i_core_clk = ~i_core_clk;
   end
   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end

   // -----------------------------
   // test sequence
   // -----------------------------
   initial begin
      i_resetn = 1'b0;
      i_por_reset = 1'b1;
      i_reg_req = '0;
      i_flash_req = 1'b0;
      i_port_match = 3'h0;
      i_cmp_en = 2'h0;
      // comparator outputs low but disabled: must not wake
      i_cmp_out = 2'h0;
      repeat (12) @(posedge i_core_clk);
      #1;
      chk("reset halt", 16'h1f, {o_cpu_halt, o_sfr_reset, o_intr_timer_disable,
          o_sp_init, o_ram_write_block});
      chk("port init", 16'h07ff, o_port_init);
      chk("reset pin", 16'h0, {o_rst_pin_oe_n, o_rst_pin_out});
      chk("src wdt lock", 16'h0, {o_system_clock_src, o_wdt_enable,
          o_pll_locked});
      @(posedge i_core_clk);
      i_resetn <= 1'b1;
      i_por_reset <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk("reset exit", 16'he, {o_pc_clear, o_wdt_enable, o_rst_pin_oe_n,
          o_cpu_halt});
      chk("pc value", 16'h0000, o_pc_value);
      @(posedge i_core_clk);
      #1;
      chk("pc clear pulse", 16'h0, o_pc_clear);
      @(posedge i_core_clk);
      rd(4'h1, 8'h00, "flash timing reset");
      rd(4'h2, 8'h01, "cache reset");
      wr(4'h9, 8'hff);
      rd(4'h9, 8'h00, "unmapped read");
      for (int t = 0; t < 4; t++) begin
         wr(4'h1, {2'b00, t[1:0], 4'h0});
         i_flash_req <= 1'b1;
         do @(posedge i_core_clk);
         while (o_system_clock_en !== 1'b1 || o_flash_busy !== 1'b0);
         i_flash_req <= 1'b0;
         hits = 0;
         repeat (12) begin
            @(posedge i_core_clk);
            #1;
            if (o_flash_rd_strobe === 1'b1 && o_system_clock_en === 1'b1) hits++;
            chk("flash power", {2{o_flash_rd_strobe}},
                {o_flash_active, !o_flash_low_power});
         end
         chk("strobe ticks", (t == 0) ? 16'h1 : 16'h2, hits);
         @(posedge i_core_clk);
      end
      wr(4'h2, 8'h00);
      wr(4'h1, 8'h10);
      wr(4'h2, 8'h01);
      chk("prefetch on", 16'h1, o_prefetch_enable);
      while (o_wdt_tick !== 1'b1) @(posedge i_core_clk);
      hits = 0;
      do begin
         @(posedge i_core_clk);
         #1;
         if (o_system_clock_en === 1'b1) hits++;
      end while (o_wdt_tick !== 1'b1);
      chk("wdt divide", 16'd12, hits);
      @(posedge i_core_clk);
      for (int i = 0; i < 5; i++) begin
         wr(4'h0, 8'h20);
         #1;
         chk("osc stopped", 16'h0, o_osc_run);
         count_en(8);
         chk("clock held", 16'h0, hits);
         if (i < 3) i_port_match <= 3'h1 << i;
         else i_cmp_en <= 2'h1 << (i - 3);
         @(posedge i_core_clk);
         i_port_match <= 3'h0;
         i_cmp_en <= 2'h0;
         count_en(8);
         chk("woken", 16'h3, {o_osc_run, hits != 0});
      end
      wr(4'h3, 8'h04);
      wr(4'h3, 8'h05);
      wr(4'h4, 8'h03);
      wr(4'h5, 8'h2a);
      wr(4'h6, 8'h10);
      rd(4'h5, 8'h2a, "filter readback");
      chk("pll cfg", 16'h2a10, {o_pll_cfg.osc_range, o_pll_cfg.loop_range,
          o_pll_cfg.mult});
      // selecting the pll before lock must leave the oscillator in charge
      wr(4'h7, 8'h01);
      count_en(6);
      chk("early select", 16'h0, o_system_clock_src);
      wr(4'h7, 8'h00);
      repeat (625) @(posedge i_core_clk);
      wr(4'h3, 8'h17);
      rd(4'h3, 8'h07, "lock not yet");
      k = 0;
      do begin
         rd(4'h3, 8'h00, "");
         k++;
      end while (got[4] !== 1'b1 && k < 40);
      chk("lock seen", 16'h17, got);
      wr(4'h7, 8'h01);
      count_en(10);
      chk("on pll", 16'h3, {o_system_clock_src, hits != 0});
      rd(4'h7, 8'h11, "active source");
      // run cleared while on the pll: lock loss must fall back to osc
      wr(4'h3, 8'h05);
      count_en(3);
      chk("lock lost", 16'h0, {o_pll_locked, o_system_clock_src});
      wr(4'h4, 8'h07);
      wr(4'h6, 8'h20);
      chk("reprog", 16'h0720, {o_pll_cfg.div, o_pll_cfg.mult});
      tally_and_finish();
   end
endmodule
